/* logic/isa_host_pkg.sv */
// constants, carriers and state types of the isa channel host
package isa_host_pkg;

    // ------------------------------------------------------------
    // synchroniser lane layout
    // ------------------------------------------------------------
    localparam int          SYNC_W   = 47;
    localparam int          SY_BCLK  = 46;
    localparam int          SY_RDY   = 45;
    localparam int          SY_NOWS  = 44;
    localparam int          SY_IO16  = 43;
    localparam int          SY_M16   = 42;
    localparam int          SY_MAST  = 41;
    localparam int          SY_PWR   = 40;
    localparam int          SY_DRQ   = 32;
    localparam int          SY_IRQ   = 16;
    localparam int          SY_DAT   = 0;
    localparam logic [46:0] SYNC_RST = {1'h0, 5'h1f, 1'h0, 8'h00,
                                        16'h0000, 16'h0000};

    // ------------------------------------------------------------
    // cycle timing and codes
    // ------------------------------------------------------------
    localparam logic [3:0]  WS16      = 4'h1;
    localparam logic [3:0]  WS8       = 4'h4;
    localparam logic [7:0]  DAK_IDLE  = 8'hff;
    localparam logic [2:0]  DMA16_CH  = 3'h5;
    localparam logic [2:0]  DMA_NO_CH = 3'h4;
    localparam int          IRQ_N     = 11;
    // irq lines from lowest rank (index 0) to highest
    localparam logic [10:0][3:0] IRQ_RANK = {4'h9, 4'ha, 4'hb, 4'hc,
                                             4'he, 4'hf, 4'h3, 4'h4,
                                             4'h5, 4'h6, 4'h7};

    // ------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------
    typedef struct packed {
        logic mrdc_b;
        logic mwtc_b;
        logic iorc_b;
        logic iowc_b;
    } cmd_t;

    localparam cmd_t CMD_IDLE = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_CMD,
        ST_END,
        ST_CASCADE
    } bus_st_t;

    typedef struct packed {
        bus_st_t     st;
        logic        bclk_p;
        logic [23:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [15:0] dout;
        logic        write;
        logic        mem;
        logic        want16;
        logic        cyc16;
        logic        second;
        logic        dma;
        logic [2:0]  chan;
        logic [3:0]  wait_cnt;
        logic        bale;
        logic        aen;
        logic        sbhe_b;
        logic        bus_oe_b;
        logic        d_oe_b;
        cmd_t        cmd;
        logic [7:0]  dak_b;
        logic        ready;
        logic        rsp_valid;
        logic        resdrv;
    } host_t;

    typedef struct packed {
        logic [15:0] irq_p;
        logic [15:0] pend;
        logic        int_valid;
        logic [3:0]  int_num;
    } arb_t;

endpackage

/* logic/isa_sync.sv */
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module isa_sync
    import isa_host_pkg::*;
#(
    parameter int              W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
)
(
    input  wire logic          clk_in,
    input  wire logic          rst_b_in,
    input  wire logic          ce_in,
    input  wire logic [W-1:0]  d_in,
    output logic      [W-1:0]  q_out
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] o;
    } sync_t;

    sync_t        s_q;
    sync_t        s_d;
    logic [W-1:0] o_nxt;

    // s1 is read only by s2; output moves once s2 and s3 agree
    for (genvar i = 0; i < W; i++)
    begin : g_bit
        assign o_nxt[i] = (s_q.s2[i] == s_q.s3[i]) ? s_q.s3[i] : s_q.o[i];
    end

    always_comb
    begin
        s_d    = s_q;
        s_d.s1 = d_in;
        s_d.s2 = s_q.s1;
        s_d.s3 = s_q.s2;
        s_d.o  = o_nxt;
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            s_q <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
        else if (ce_in)
            s_q <= s_d;
    end

    assign q_out = s_q.o;

endmodule

/* logic/isa_arb.sv */
// dma request priority and edge-triggered interrupt ranking
`timescale 1ns/10ps
module isa_arb
    import isa_host_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    input  wire logic        ce_in,
    input  wire logic [7:0]  drq_in,
    input  wire logic [15:0] irq_in,
    input  wire logic        int_ack_in,
    output logic             dma_any_out,
    output logic      [2:0]  dma_chan_out,
    output logic             int_valid_out,
    output logic      [3:0]  int_num_out
);

    arb_t        a_q;
    arb_t        a_d;
    logic [15:0] rise;
    logic [15:0] clr;

    // ------------------------------------------------------------
    // dma: channel 0 wins, 4 is not a channel
    // ------------------------------------------------------------
    always_comb
    begin
        dma_any_out  = 1'b0;
        dma_chan_out = DMA_NO_CH;
        for (int i = 7; i >= 0; i--)
        begin
            if (i != 4 && drq_in[i])
            begin
                dma_any_out  = 1'b1;
                dma_chan_out = 3'(i);
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    always_comb
    begin
        a_d  = a_q;
        rise = irq_in & ~a_q.irq_p;
        clr  = '0;
        if (int_ack_in && a_q.int_valid)
            clr[a_q.int_num] = 1'b1;
        a_d.irq_p = irq_in;
        // a new edge beats an acknowledge in the same cycle
        a_d.pend = (a_q.pend & ~clr) | rise;
        a_d.int_valid = 1'b0;
        a_d.int_num   = a_q.int_num;
        for (int i = 0; i < IRQ_N; i++)
        begin
            if (a_d.pend[IRQ_RANK[i]])
            begin
                a_d.int_valid = 1'b1;
                a_d.int_num   = IRQ_RANK[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
            a_q <= '0;
        else if (ce_in)
            a_q <= a_d;
    end

    assign int_valid_out = a_q.int_valid;
    assign int_num_out   = a_q.int_num;

endmodule

/* logic/isa_io_channel_host.sv */
// host end of a 16-bit isa i/o channel: cycles, dma, irq, reset drive
`timescale 1ns/10ps
module isa_io_channel_host
    import isa_host_pkg::*;
(
    input  wire logic        CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic        CE_IN,
    input  wire logic        PWR_GOOD_IN,
    input  wire logic        REQ_VALID_IN,
    input  wire logic        REQ_WRITE_IN,
    input  wire logic        REQ_MEM_IN,
    input  wire logic        REQ_WIDE_IN,
    input  wire logic [23:0] REQ_ADDR_IN,
    input  wire logic [15:0] REQ_WDATA_IN,
    output logic             REQ_READY_OUT,
    output logic             RSP_VALID_OUT,
    output logic      [15:0] RSP_RDATA_OUT,
    input  wire logic [23:0] DMA_ADDR_IN,
    input  wire logic        DMA_TO_MEM_IN,
    input  wire logic        INT_ACK_IN,
    output logic             INT_VALID_OUT,
    output logic      [3:0]  INT_NUM_OUT,
    input  wire logic        BCLK_IN,
    input  wire logic        CHRDY_IN,
    input  wire logic        NOWS_B_IN,
    input  wire logic        IO16_B_IN,
    input  wire logic        M16_B_IN,
    input  wire logic        MASTER16_B_IN,
    input  wire logic [7:0]  DRQ_IN,
    input  wire logic [15:0] IRQ_IN,
    input  wire logic [15:0] D_IN,
    output logic      [15:0] D_OUT,
    output logic             D_OE_B_OUT,
    output logic      [19:0] SA_OUT,
    output logic      [6:0]  LA_OUT,
    output logic             SBHE_B_OUT,
    output logic             BALE_OUT,
    output logic             AEN_OUT,
    output cmd_t             CMD_B_OUT,
    output logic             BUS_OE_B_OUT,
    output logic      [7:0]  DAK_B_OUT,
    output logic             RESDRV_OUT
);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [SYNC_W-1:0] sy;
    logic              bclk_s;
    logic              rdy_s;
    logic              nows_b_s;
    logic              io16_b_s;
    logic              m16_b_s;
    logic              mast_b_s;
    logic              pwr_s;
    logic [7:0]        drq_s;
    logic [15:0]       irq_s;
    logic [15:0]       d_s;

    isa_sync #(
        .W       (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .clk_in   (CLK_IN),
        .rst_b_in (RST_B_IN),
        .ce_in    (CE_IN),
        .d_in     ({BCLK_IN, CHRDY_IN, NOWS_B_IN, IO16_B_IN, M16_B_IN,
                    MASTER16_B_IN, PWR_GOOD_IN, DRQ_IN, IRQ_IN, D_IN}),
        .q_out    (sy)
    );

    assign bclk_s   = sy[SY_BCLK];
    assign rdy_s    = sy[SY_RDY];
    assign nows_b_s = sy[SY_NOWS];
    assign io16_b_s = sy[SY_IO16];
    assign m16_b_s  = sy[SY_M16];
    assign mast_b_s = sy[SY_MAST];
    assign pwr_s    = sy[SY_PWR];
    assign drq_s    = sy[SY_DRQ +: 8];
    assign irq_s    = sy[SY_IRQ +: 16];
    assign d_s      = sy[SY_DAT +: 16];

    // ------------------------------------------------------------
    // arbitration
    // ------------------------------------------------------------
    logic       dma_any;
    logic [2:0] dma_chan;

    isa_arb u_arb (
        .clk_in        (CLK_IN),
        .rst_b_in      (RST_B_IN),
        .ce_in         (CE_IN),
        .drq_in        (drq_s),
        .irq_in        (irq_s),
        .int_ack_in    (INT_ACK_IN),
        .dma_any_out   (dma_any),
        .dma_chan_out  (dma_chan),
        .int_valid_out (INT_VALID_OUT),
        .int_num_out   (INT_NUM_OUT)
    );

    // ------------------------------------------------------------
    // bus cycle engine
    // ------------------------------------------------------------
    host_t h_q;
    host_t h_d;
    logic  tick;
    logic  hi_lane;
    logic  done;

    // cycles advance on bus clock rising edges seen by CLK_IN
    assign tick = bclk_s & ~h_q.bclk_p;
    assign hi_lane = h_q.addr[0] | (h_q.want16 & ~h_q.second);
    // no-wait select cuts the wait count short
    assign done = ~nows_b_s | (h_q.wait_cnt == 4'h0 & rdy_s);

    always_comb
    begin
        h_d           = h_q;
        h_d.bclk_p    = bclk_s;
        h_d.rsp_valid = 1'b0;
        h_d.resdrv    = ~pwr_s;
        if (h_q.resdrv || !pwr_s)
        begin
            // channel held in reset; nothing runs
            h_d.st       = ST_IDLE;
            h_d.ready    = 1'b0;
            h_d.bale     = 1'b0;
            h_d.aen      = 1'b0;
            h_d.cmd      = CMD_IDLE;
            h_d.dak_b    = DAK_IDLE;
            h_d.d_oe_b   = 1'b1;
            h_d.sbhe_b   = 1'b1;
            h_d.bus_oe_b = 1'b0;
            h_d.ready    = ~pwr_s ? 1'b0 : 1'b1;
        end
        else
        begin
            case (h_q.st)
                ST_IDLE:
                begin
                    if (h_q.ready && REQ_VALID_IN)
                    begin
                        h_d.st     = ST_ADDR;
                        h_d.ready  = 1'b0;
                        h_d.dma    = 1'b0;
                        h_d.addr   = REQ_ADDR_IN;
                        h_d.wdata  = REQ_WDATA_IN;
                        h_d.write  = REQ_WRITE_IN;
                        h_d.mem    = REQ_MEM_IN;
                        h_d.want16 = REQ_WIDE_IN;
                        h_d.second = 1'b0;
                        h_d.rdata  = 16'h0000;
                        h_d.bale   = 1'b1;
                    end
                    else if (dma_any)
                    begin
                        // processor degated while address enable is up
                        h_d.st     = ST_ADDR;
                        h_d.ready  = 1'b0;
                        h_d.dma    = 1'b1;
                        h_d.aen    = 1'b1;
                        h_d.bale   = 1'b1;
                        h_d.chan   = dma_chan;
                        h_d.dak_b  = DAK_IDLE;
                        h_d.dak_b[dma_chan] = 1'b0;
                        h_d.addr   = DMA_ADDR_IN;
                        h_d.write  = DMA_TO_MEM_IN;
                        h_d.mem    = 1'b1;
                        h_d.want16 = dma_chan >= DMA16_CH;
                        h_d.second = 1'b0;
                    end
                end
                ST_ADDR:
                begin
                    if (tick)
                    begin
                        if (h_q.dma && !mast_b_s)
                        begin
                            // a channel master takes the bus over
                            h_d.st       = ST_CASCADE;
                            h_d.bus_oe_b = 1'b1;
                            h_d.d_oe_b   = 1'b1;
                        end
                        else
                        begin
                            h_d.st     = ST_CMD;
                            // falling strobe latches the address; in dma the strobe stays high
                            h_d.bale   = h_q.dma;
                            h_d.sbhe_b = ~hi_lane;
                            if (h_q.dma)
                            begin
                                h_d.cyc16    = h_q.want16;
                                h_d.wait_cnt = h_q.want16 ? WS16 : WS8;
                                h_d.cmd      = CMD_IDLE;
                                h_d.cmd.iorc_b = ~h_q.write;
                                h_d.cmd.mwtc_b = ~h_q.write;
                                h_d.cmd.mrdc_b = h_q.write;
                                h_d.cmd.iowc_b = h_q.write;
                                h_d.d_oe_b   = 1'b1;
                            end
                            else
                            begin
                                // decodes sampled at the strobe fall
                                h_d.cyc16 = h_q.want16 & ~h_q.addr[0]
                                    & (h_q.mem ? ~m16_b_s
                                               : ~io16_b_s);
                                h_d.wait_cnt = h_d.cyc16 ? WS16 : WS8;
                                h_d.cmd = CMD_IDLE;
                                if (h_q.mem)
                                begin
                                    h_d.cmd.mwtc_b = ~h_q.write;
                                    h_d.cmd.mrdc_b = h_q.write;
                                end
                                else
                                begin
                                    h_d.cmd.iowc_b = ~h_q.write;
                                    h_d.cmd.iorc_b = h_q.write;
                                end
                                h_d.d_oe_b = ~h_q.write;
                                if (h_d.cyc16)
                                    h_d.dout = h_q.wdata;
                                else if (h_q.addr[0] || h_q.second)
                                    h_d.dout = {2{h_q.wdata[15:8]}};
                                else
                                    h_d.dout = {2{h_q.wdata[7:0]}};
                            end
                        end
                    end
                end
                ST_CMD:
                begin
                    if (tick)
                    begin
                        if (done)
                        begin
                            h_d.cmd    = CMD_IDLE;
                            h_d.d_oe_b = 1'b1;
                            if (h_q.cyc16)
                                h_d.rdata = d_s;
                            else if (h_q.addr[0])
                                h_d.rdata[15:8] = d_s[7:0];
                            else
                                h_d.rdata[7:0] = d_s[7:0];
                            if (!h_q.dma && h_q.want16 && !h_q.cyc16
                                && !h_q.second && !h_q.addr[0])
                            begin
                                // second byte of a split word
                                h_d.st     = ST_ADDR;
                                h_d.second = 1'b1;
                                h_d.addr   = h_q.addr + 24'h000001;
                                h_d.bale   = 1'b1;
                            end
                            else
                                h_d.st = ST_END;
                        end
                        else if (h_q.wait_cnt != 4'h0)
                            h_d.wait_cnt = h_q.wait_cnt - 4'h1;
                        // else ready low: stretch by whole clocks
                    end
                end
                ST_END:
                begin
                    if (tick)
                    begin
                        h_d.st        = ST_IDLE;
                        h_d.bale      = 1'b0;
                        h_d.aen       = 1'b0;
                        h_d.dak_b     = DAK_IDLE;
                        h_d.sbhe_b    = 1'b1;
                        h_d.rsp_valid = ~h_q.dma;
                        h_d.ready     = 1'b1;
                    end
                end
                ST_CASCADE:
                begin
                    // hold acknowledge until the master lets go
                    if (!drq_s[h_q.chan] && mast_b_s)
                    begin
                        h_d.st       = ST_IDLE;
                        h_d.bale     = 1'b0;
                        h_d.aen      = 1'b0;
                        h_d.dak_b    = DAK_IDLE;
                        h_d.bus_oe_b = 1'b0;
                        h_d.ready    = 1'b1;
                    end
                end
                default:
                    h_d.st = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_B_IN)
    begin
        if (!RST_B_IN)
        begin
            h_q          <= '0;
            h_q.st       <= ST_IDLE;
            h_q.sbhe_b   <= 1'b1;
            h_q.d_oe_b   <= 1'b1;
            h_q.cmd      <= CMD_IDLE;
            h_q.dak_b    <= DAK_IDLE;
            h_q.resdrv   <= 1'b1;
        end
        else if (CE_IN)
            h_q <= h_d;
    end

    // ------------------------------------------------------------
    // outputs, all from the state register
    // ------------------------------------------------------------
    assign REQ_READY_OUT = h_q.ready;
    assign RSP_VALID_OUT = h_q.rsp_valid;
    assign RSP_RDATA_OUT = h_q.rdata;
    assign D_OUT         = h_q.dout;
    assign D_OE_B_OUT    = h_q.d_oe_b;
    assign SA_OUT        = h_q.addr[19:0];
    assign LA_OUT        = h_q.addr[23:17];
    assign SBHE_B_OUT    = h_q.sbhe_b;
    assign BALE_OUT      = h_q.bale;
    assign AEN_OUT       = h_q.aen;
    assign CMD_B_OUT     = h_q.cmd;
    assign BUS_OE_B_OUT  = h_q.bus_oe_b;
    assign DAK_B_OUT     = h_q.dak_b;
    assign RESDRV_OUT    = h_q.resdrv;

endmodule

/* test/isa_host_assertions.sv */
// port-level assertion checker for the isa channel host
`timescale 1ns/10ps
module isa_host_assertions
    import isa_host_pkg::*;
(
    input  wire logic       CLK_IN,
    input  wire logic       RST_B_IN,
    input  wire logic       PWR_GOOD_IN,
    input  wire logic       REQ_READY_OUT,
    input  wire logic       RSP_VALID_OUT,
    input  wire logic       SBHE_B_OUT,
    input  wire logic       BALE_OUT,
    input  wire logic       AEN_OUT,
    input  wire cmd_t       CMD_B_OUT,
    input  wire logic [7:0] DAK_B_OUT,
    input  wire logic       RESDRV_OUT
);
    // --------------------------------------------------------
    // properties
    // --------------------------------------------------------
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    property p_dak_one;
        DAK_B_OUT[4] && $onehot0(~DAK_B_OUT);
    endproperty
    property p_dak_aen;
        DAK_B_OUT != 8'hff |-> AEN_OUT;
    endproperty
    property p_aen_bale;
        AEN_OUT |-> BALE_OUT;
    endproperty
    property p_byte_dma;
        DAK_B_OUT[3:0] != 4'hf |-> SBHE_B_OUT;
    endproperty
    property p_word_dma;
        DAK_B_OUT[7:5] != 3'h7 && CMD_B_OUT != CMD_IDLE |-> !SBHE_B_OUT;
    endproperty
    // sync plus filter delay bounds the reaction
    property p_pwr;
        !PWR_GOOD_IN |-> ##[1:8] RESDRV_OUT;
    endproperty
    property p_res_idle;
        RESDRV_OUT |-> !REQ_READY_OUT && CMD_B_OUT == CMD_IDLE;
    endproperty
    property p_rsp_pulse;
        RSP_VALID_OUT |=> !RSP_VALID_OUT;
    endproperty

    a_dak_one: assert property (p_dak_one)
        else $error("acknowledge not one-hot");
    a_dak_aen: assert property (p_dak_aen)
        else $error("acknowledge without address enable");
    a_aen_bale: assert property (p_aen_bale)
        else $error("latch strobe low during dma");
    a_byte_dma: assert property (p_byte_dma)
        else $error("byte dma uses upper lane");
    a_word_dma: assert property (p_word_dma)
        else $error("word dma without high enable");
    a_pwr: assert property (p_pwr)
        else $error("no reset drive on power loss");
    a_res_idle: assert property (p_res_idle)
        else $error("activity during reset drive");
    a_rsp_pulse: assert property (p_rsp_pulse)
        else $error("response longer than one cycle");

    c_word_dma: cover property (DAK_B_OUT[5] == 1'h0);
    c_rsp: cover property (RSP_VALID_OUT);
    c_pwr: cover property (!PWR_GOOD_IN ##1 RESDRV_OUT);
endmodule

bind isa_io_channel_host isa_host_assertions u_chk (.*);

/* test/isa_card_model.sv */
// behavioural isa add-in card answering the host's cycles
`timescale 1ns/10ps
module isa_card_model
    import isa_host_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic        wide_in,
    input  wire logic        slow_in,
    input  wire logic [15:0] rdata_in,
    input  wire cmd_t        cmd_in,
    output logic      [15:0] d_out,
    output logic             chrdy_out,
    output logic             io16_b_out,
    output logic             m16_b_out
);
    logic [7:0]  stall_q = 8'h00;
    logic [15:0] d_q     = 16'h0000;
    logic        rd;

    assign rd         = !cmd_in.mrdc_b || !cmd_in.iorc_b;
    // every address decodes to this card while wide
    assign io16_b_out = !wide_in;
    assign m16_b_out  = !wide_in;
    // not-ready falls with the command, 800 ns, far below the limit
    assign chrdy_out  = !(slow_in && cmd_in != CMD_IDLE
                          && stall_q < 8'h64);
    // released bus shows a changing pattern, never the last value
    assign d_out      = rd ? rdata_in : d_q;

    always @(posedge clk_in)
    begin
        stall_q <= (cmd_in == CMD_IDLE) ? 8'h00
                 : stall_q + {7'h00, stall_q != 8'hff};
        d_q     <= ~d_out;
    end
endmodule

/* test/isa_io_channel_host_tb.sv */
// self-checking bench for the isa channel host
`timescale 1ns/10ps
module isa_io_channel_host_tb
    import isa_host_pkg::*;
;
    logic        CLK_IN = 0, RST_B_IN = 0, CE_IN = 1, PWR_GOOD_IN = 1;
    logic        REQ_VALID_IN = 0, REQ_WRITE_IN = 0, REQ_MEM_IN = 0;
    logic        REQ_WIDE_IN = 0, DMA_TO_MEM_IN = 0, INT_ACK_IN = 0;
    logic        BCLK_IN = 0, NOWS_B_IN = 1, MASTER16_B_IN = 1;
    logic        CHRDY_IN, IO16_B_IN, M16_B_IN, slow = 0, wide = 0, sb;
    logic        REQ_READY_OUT, RSP_VALID_OUT, INT_VALID_OUT, D_OE_B_OUT;
    logic        SBHE_B_OUT, BALE_OUT, AEN_OUT, BUS_OE_B_OUT, RESDRV_OUT;
    logic [23:0] REQ_ADDR_IN = 0, DMA_ADDR_IN = 24'h001000;
    logic [15:0] REQ_WDATA_IN = 0, IRQ_IN = 0, D_IN, D_OUT, RSP_RDATA_OUT;
    logic [15:0] rdat = 0, dv;
    logic [7:0]  DRQ_IN = 0, DAK_B_OUT;
    logic [19:0] SA_OUT;
    logic [6:0]  LA_OUT;
    logic [3:0]  INT_NUM_OUT;
    cmd_t        CMD_B_OUT;
    int          err_count = 0, checks = 0, dur, nb, i, n;

    always #4 CLK_IN = ~CLK_IN;
    initial #37 forever #80 BCLK_IN = ~BCLK_IN;

    isa_io_channel_host u_dut (.*);
    isa_card_model u_card (.clk_in(CLK_IN), .wide_in(wide), .slow_in(slow),
        .rdata_in(rdat), .cmd_in(CMD_B_OUT), .d_out(D_IN),
        .chrdy_out(CHRDY_IN), .io16_b_out(IO16_B_IN), .m16_b_out(M16_B_IN));

    // --------------------------------------------------------
    // shared tasks
    // --------------------------------------------------------
    task automatic tick(input int c);
        repeat (c) @(posedge CLK_IN);
        #1;
    endtask

    task automatic cmp(input logic [15:0] got, exp);
        checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic w, m, wd, input logic [23:0] a,
                        input logic [15:0] d);
        logic pb;
        {REQ_VALID_IN, REQ_WRITE_IN, REQ_MEM_IN, REQ_WIDE_IN} = {1'h1, w, m, wd};
        REQ_ADDR_IN  = a;
        REQ_WDATA_IN = d;
        n = 0;
        while (REQ_READY_OUT !== 1'h1 && n < 500)
        begin
            tick(1);
            n++;
        end
        tick(1);
        REQ_VALID_IN = 1'h0;
        {dur, nb, pb} = 0;
        while (RSP_VALID_OUT !== 1'h1 && dur < 3000)
        begin
            nb = nb + (BALE_OUT === 1'h1 && pb !== 1'h1);
            pb = BALE_OUT;
            if (CMD_B_OUT !== CMD_IDLE)
                {sb, dv} = {SBHE_B_OUT, D_OUT};
            tick(1);
            dur++;
        end
        cmp({15'h0, RSP_VALID_OUT}, 16'h1);
    endtask

    task automatic dak_idle(input logic want);
        n = 0;
        while ((DAK_B_OUT === 8'hff) !== want && n < 2000)
        begin
            tick(1);
            n++;
        end
        cmp({15'h0, n < 2000}, 16'h1);
    endtask

    // --------------------------------------------------------
    // scenarios
    // --------------------------------------------------------
    task automatic t_cycles();
        {wide, rdat} = {1'h1, 16'h1234};
        xfer(1'h0, 1'h1, 1'h1, 24'h0a0000, 16'h0);
        cmp(RSP_RDATA_OUT, 16'h1234);
        cmp({LA_OUT, SA_OUT[19:11]}, 16'h0b40);
        cmp({14'h0, sb, nb[0]}, 16'h1);
        i = dur;
        slow = 1'h1;
        xfer(1'h0, 1'h1, 1'h1, 24'h0a0000, 16'h0);
        cmp({15'h0, dur > i + 80}, 16'h1);
        slow = 1'h0;
        xfer(1'h1, 1'h0, 1'h1, 24'h000300, 16'hbeef);
        cmp(dv, 16'hbeef);
    endtask

    task automatic t_split();
        {wide, rdat} = {1'h0, 16'h5aa5};
        xfer(1'h0, 1'h1, 1'h1, 24'h0c0000, 16'h0);
        cmp(RSP_RDATA_OUT, 16'ha5a5);
        cmp({15'h0, nb == 2}, 16'h1);
        xfer(1'h1, 1'h0, 1'h1, 24'h000300, 16'h3c5a);
        cmp({8'h0, dv[7:0]}, 16'h003c);
        xfer(1'h0, 1'h0, 1'h0, 24'h000300, 16'h0);
        i = dur;
        NOWS_B_IN = 1'h0;
        xfer(1'h0, 1'h0, 1'h0, 24'h000300, 16'h0);
        cmp({15'h0, dur < i}, 16'h1);
        NOWS_B_IN = 1'h1;
    endtask

    task automatic t_dma();
        int ch[4] = '{0, 2, 5, 7};
        DRQ_IN = 8'hb5;
        foreach (ch[k])
        begin
            dak_idle(1'h0);
            cmp({8'h0, DAK_B_OUT}, {8'h0, ~(8'h01 << ch[k])});
            DRQ_IN[ch[k]] = 1'h0;
            dak_idle(1'h1);
        end
        tick(100);
        cmp({8'h0, DAK_B_OUT}, 16'h00ff);
        @(negedge BCLK_IN) DRQ_IN = 8'h40;
        dak_idle(1'h0);
        MASTER16_B_IN = 1'h0;
        tick(99);
        cmp({14'h0, BUS_OE_B_OUT, AEN_OUT}, 16'h3);
        {DRQ_IN, MASTER16_B_IN} = 9'h001;
        dak_idle(1'h1);
    endtask

    task automatic t_irq();
        logic [3:0] ex[3] = '{4'h9, 4'h3, 4'h7};
        IRQ_IN = 16'h0088;
        tick(10);
        IRQ_IN[9] = 1'h1;
        tick(10);
        foreach (ex[k])
        begin
            cmp({12'h0, INT_NUM_OUT}, {12'h0, ex[k]});
            INT_ACK_IN = 1'h1;
            tick(1);
            INT_ACK_IN = 1'h0;
            tick(4);
        end
        cmp({15'h0, INT_VALID_OUT}, 16'h0);
    endtask

    task automatic t_power();
        PWR_GOOD_IN = 1'h0;
        tick(12);
        cmp({14'h0, RESDRV_OUT, REQ_READY_OUT}, 16'h2);
        PWR_GOOD_IN = 1'h1;
        tick(12);
        cmp({15'h0, RESDRV_OUT}, 16'h0);
    endtask

    task automatic stop_test();
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial
    begin
        tick(1);
        cmp({7'h0, RESDRV_OUT, DAK_B_OUT}, 16'h01ff);
        tick(3);
        RST_B_IN = 1'h1;
        tick(20);
        t_cycles();
        t_split();
        t_dma();
        t_irq();
        t_power();
        stop_test();
    end

    initial
    begin
        #400000;
        err_count++;
        stop_test();
    end
endmodule
